// [ats_timer_top.v]
// Purpose: 8-bit timer with asynchronous clock option and update sync
// Assumes: APB slave, inputs synchronous to sys_clk, osc pin << sys_clk/4
// Notes:   Oscillator pin is sampled and edge detected in sys_clk
//
// Register access over APB is decoded and read back in this module.
`timescale 1ns/10ps
`include "ats_defs.vh"

module ats_timer_top #(
	parameter WIDTH = 8
) (
	input  wire        sys_clk,     // System clock, 25 MHz
	input  wire        rst_n,       // Asynchronous reset, active low
	input  wire        psel,        // APB select
	input  wire        penable,     // APB enable
	input  wire        pwrite,      // APB direction, high for write
	input  wire [11:0] paddr,       // APB byte address
	input  wire [31:0] pwdata,      // APB write data
	output reg  [31:0] prdata,      // APB read data, registered
	output wire        pready,      // APB ready, always high
	output wire        pslverr,     // APB error on unmapped address
	input  wire        oscClockPin, // Timer oscillator pin level
	input  wire        powerSave,   // Processor in power save
	input  wire        powerDown,   // Processor in power-down
	output wire        oscRun,      // Oscillator enable
	output reg         wakeReq,     // Wake request from timer
	output reg         cmpOut,      // Compare output pin
	output wire        ovfFlag,     // Overflow flag level
	output wire        cmpFlag      // Compare flag level
);

	// Reset release
	reg rstMeta_reg;
	reg rstSync_reg;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end

	wire rstN = rstSync_reg;

	// Register state
	reg             asyncSel_reg;
	reg [WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] compare_reg;
	reg [WIDTH-1:0] control_reg;
	reg             ovfEn_reg;
	reg             cmpEn_reg;
	reg [1:0]       flag_reg;

	// Bus decode
	reg  mapped;
	reg  wrCount;
	reg  wrCompare;
	reg  wrControl;
	reg  wrStatus;
	reg  wrIrq;
	wire apbAccess = psel & penable;
	wire apbWrite  = apbAccess & pwrite;

	always @* begin
		mapped    = 1'b0;
		wrCount   = 1'b0;
		wrCompare = 1'b0;
		wrControl = 1'b0;
		wrStatus  = 1'b0;
		wrIrq     = 1'b0;
		if (paddr == `ATS_ADDR_STATUS) begin
			mapped   = 1'b1;
			wrStatus = apbWrite;
		end else if (paddr == `ATS_ADDR_COUNT) begin
			mapped  = 1'b1;
			wrCount = apbWrite;
		end else if (paddr == `ATS_ADDR_COMPARE) begin
			mapped    = 1'b1;
			wrCompare = apbWrite;
		end else if (paddr == `ATS_ADDR_CONTROL) begin
			mapped    = 1'b1;
			wrControl = apbWrite;
		end else if (paddr == `ATS_ADDR_IRQ) begin
			mapped = 1'b1;
			wrIrq  = apbWrite;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = apbAccess & ~mapped;

	// Oscillator pin synchroniser and edge detect
	reg  oscMeta_reg;
	reg  oscSync_reg;
	reg  oscLast_reg;
	wire oscRise = oscSync_reg & ~oscLast_reg;

	always @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			oscMeta_reg <= 1'b0;
			oscSync_reg <= 1'b0;
			oscLast_reg <= 1'b0;
		end else begin
			oscMeta_reg <= oscClockPin;
			oscSync_reg <= oscMeta_reg;
			oscLast_reg <= oscSync_reg;
		end
	end

	assign oscRun = asyncSel_reg & ~powerDown;

	// Holding registers, one per destination
	wire [WIDTH-1:0] cntHold;
	wire [WIDTH-1:0] cmpHold;
	wire [WIDTH-1:0] ctlHold;
	wire             cntLoad;
	wire             cmpLoad;
	wire             ctlLoad;
	wire             cntBusy;
	wire             cmpBusy;
	wire             ctlBusy;

	ats_update_slot #(.WIDTH(WIDTH)) uCountSlot (
		.clk       (sys_clk),
		.rstN      (rstN),
		.wrStrobe  (wrCount),
		.wrData    (pwdata[WIDTH-1:0]),
		.asyncMode (asyncSel_reg),
		.oscTick   (oscRise),
		.holdValue (cntHold),
		.loadPulse (cntLoad),
		.busy      (cntBusy)
	);

	ats_update_slot #(.WIDTH(WIDTH)) uCompareSlot (
		.clk       (sys_clk),
		.rstN      (rstN),
		.wrStrobe  (wrCompare),
		.wrData    (pwdata[WIDTH-1:0]),
		.asyncMode (asyncSel_reg),
		.oscTick   (oscRise),
		.holdValue (cmpHold),
		.loadPulse (cmpLoad),
		.busy      (cmpBusy)
	);

	ats_update_slot #(.WIDTH(WIDTH)) uControlSlot (
		.clk       (sys_clk),
		.rstN      (rstN),
		.wrStrobe  (wrControl),
		.wrData    (pwdata[WIDTH-1:0]),
		.asyncMode (asyncSel_reg),
		.oscTick   (oscRise),
		.holdValue (ctlHold),
		.loadPulse (ctlLoad),
		.busy      (ctlBusy)
	);

	// Timer clock source and prescaler
	wire       srcEdge = asyncSel_reg ? oscRise : 1'b1;
	reg  [9:0] prescale_reg;
	reg        tick;
	wire [2:0] clkSel  = control_reg[`ATS_CTL_CS_MSB:`ATS_CTL_CS_LSB];

	always @* begin
		case (clkSel)
			`ATS_CS_DIV1:    tick = srcEdge;
			`ATS_CS_DIV8:    tick = srcEdge & (prescale_reg[2:0] == 3'h7);
			`ATS_CS_DIV64:   tick = srcEdge & (prescale_reg[5:0] == 6'h3F);
			`ATS_CS_DIV256:  tick = srcEdge & (prescale_reg[7:0] == 8'hFF);
			`ATS_CS_DIV1024: tick = srcEdge & (prescale_reg == 10'h3FF);
			default:         tick = 1'b0;
		endcase
	end

	// Counting, compare and overflow
	wire             ctcMode  = control_reg[`ATS_CTL_CTC];
	wire [1:0]       comMode  = control_reg[`ATS_CTL_COM_MSB:`ATS_CTL_COM_LSB];
	wire             ctcClear = ctcMode & (count_reg == compare_reg);
	wire [WIDTH-1:0] countInc = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
	wire [WIDTH-1:0] countNext = ctcClear ? {WIDTH{1'b0}} : countInc;
	wire             suppress = cmpBusy | cntBusy;
	// Only counting onto the compare value matches, never a software load
	wire             matchNow = tick & ~cntLoad & ~suppress &
	                            (countNext == compare_reg);
	wire             ovfNow   = tick & ~cntLoad & ~ctcClear &
	                            (count_reg == {WIDTH{1'b1}});
	reg  [1:0]       evt_reg;

	always @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			prescale_reg <= 10'h000;
			count_reg    <= `ATS_RST_BYTE;
			compare_reg  <= `ATS_RST_BYTE;
			control_reg  <= `ATS_RST_BYTE;
			evt_reg      <= 2'h0;
			cmpOut       <= 1'b0;
		end else begin
			if (srcEdge)
				prescale_reg <= prescale_reg + 10'h001;
			if (cntLoad)
				count_reg <= cntHold;
			else if (tick)
				count_reg <= countNext;
			if (cmpLoad)
				compare_reg <= cmpHold;
			if (ctlLoad)
				control_reg <= ctlHold;
			evt_reg <= {matchNow, ovfNow};
			if (matchNow) begin
				case (comMode)
					2'h1:    cmpOut <= ~cmpOut;
					2'h2:    cmpOut <= 1'b0;
					2'h3:    cmpOut <= 1'b1;
					default: cmpOut <= cmpOut;
				endcase
			end
		end
	end

	// Flag synchronisation: bit 0 overflow, bit 1 compare
	wire [1:0] flagSet;
	wire [1:0] flagPend;
	wire [1:0] flagClr = wrIrq ? {pwdata[`ATS_IRQ_CMP_FLAG],
	                              pwdata[`ATS_IRQ_OVF_FLAG]} : 2'h0;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : gFlag
			reg                       pend_reg;
			reg [`ATS_FLAG_SYNC-1:0]  dly_reg;
			always @(posedge sys_clk or negedge rstN) begin
				if (!rstN) begin
					pend_reg <= 1'b0;
					dly_reg  <= {`ATS_FLAG_SYNC{1'b0}};
				end else begin
					// Wait one timer cycle, then three system cycles
					dly_reg <= {dly_reg[`ATS_FLAG_SYNC-2:0],
					            pend_reg & oscRise};
					if (evt_reg[gi] & asyncSel_reg)
						pend_reg <= 1'b1;
					else if (oscRise)
						pend_reg <= 1'b0;
				end
			end
			assign flagPend[gi] = pend_reg;
			assign flagSet[gi]  = asyncSel_reg ? dly_reg[`ATS_FLAG_SYNC-1]
			                                   : evt_reg[gi];
		end
	endgenerate

	always @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			flag_reg <= 2'h0;
		else
			flag_reg <= flagSet | (flag_reg & ~flagClr);
	end

	assign ovfFlag = flag_reg[0];
	assign cmpFlag = flag_reg[1];

	// Wake request in power save on the timer cycle after an enabled condition, async mode only
	wire [1:0] enMask = {cmpEn_reg, ovfEn_reg};

	always @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			wakeReq <= 1'b0;
		else if (!powerSave)
			wakeReq <= 1'b0;
		else if (oscRise && ((flagPend & enMask) != 2'h0))
			wakeReq <= 1'b1;
	end

	// Software control bits
	always @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			asyncSel_reg <= 1'b0;
			ovfEn_reg    <= 1'b0;
			cmpEn_reg    <= 1'b0;
		end else begin
			if (wrStatus)
				asyncSel_reg <= pwdata[`ATS_ST_ASYNC];
			if (wrIrq) begin
				ovfEn_reg <= pwdata[`ATS_IRQ_OVF_EN];
				cmpEn_reg <= pwdata[`ATS_IRQ_CMP_EN];
			end
		end
	end

	// Read data, captured in the setup cycle
	reg [31:0] readMux;

	always @* begin
		readMux = `ATS_RST_WORD;
		if (paddr == `ATS_ADDR_STATUS) begin
			readMux[`ATS_ST_ASYNC]    = asyncSel_reg;
			readMux[`ATS_ST_CNT_BUSY] = cntBusy;
			readMux[`ATS_ST_CMP_BUSY] = cmpBusy;
			readMux[`ATS_ST_CTL_BUSY] = ctlBusy;
		end else if (paddr == `ATS_ADDR_COUNT) begin
			readMux[WIDTH-1:0] = count_reg;
		end else if (paddr == `ATS_ADDR_COMPARE) begin
			readMux[WIDTH-1:0] = cmpHold;
		end else if (paddr == `ATS_ADDR_CONTROL) begin
			readMux[WIDTH-1:0] = ctlHold;
		end else if (paddr == `ATS_ADDR_IRQ) begin
			readMux[`ATS_IRQ_OVF_EN]   = ovfEn_reg;
			readMux[`ATS_IRQ_CMP_EN]   = cmpEn_reg;
			readMux[`ATS_IRQ_OVF_FLAG] = flag_reg[0];
			readMux[`ATS_IRQ_CMP_FLAG] = flag_reg[1];
		end
	end

	always @(posedge sys_clk or negedge rstN) begin
		if (!rstN)
			prdata <= `ATS_RST_WORD;
		else if (psel && !penable && !pwrite)
			prdata <= readMux;
	end

endmodule // ats_timer_top

// [ats_defs.vh]
// Purpose: Shared constants of the asynchronous timer update block
// Assumes: Included by bare name from every design file
// Notes:   Byte addresses on a 32-bit APB, one aligned word per register
`ifndef ATS_DEFS_VH
`define ATS_DEFS_VH

// Register byte addresses
`define ATS_ADDR_STATUS   12'h030
`define ATS_ADDR_COUNT    12'h034
`define ATS_ADDR_COMPARE  12'h038
`define ATS_ADDR_CONTROL  12'h03C
`define ATS_ADDR_IRQ      12'h040

// Status register fields
`define ATS_ST_CTL_BUSY   0
`define ATS_ST_CMP_BUSY   1
`define ATS_ST_CNT_BUSY   2
`define ATS_ST_ASYNC      3

// Timer control fields
`define ATS_CTL_CS_LSB    0
`define ATS_CTL_CS_MSB    2
`define ATS_CTL_CTC       3
`define ATS_CTL_COM_LSB   4
`define ATS_CTL_COM_MSB   5

// Interrupt enable and flag fields
`define ATS_IRQ_OVF_EN    0
`define ATS_IRQ_CMP_EN    1
`define ATS_IRQ_OVF_FLAG  8
`define ATS_IRQ_CMP_FLAG  9

// Reset values
`define ATS_RST_BYTE      8'h00
`define ATS_RST_WORD      32'h0000_0000

// Timing counts
`define ATS_XFER_EDGES    2'h2
`define ATS_FLAG_SYNC     3

// Clock select codes
`define ATS_CS_DIV1       3'h1
`define ATS_CS_DIV8       3'h2
`define ATS_CS_DIV64      3'h3
`define ATS_CS_DIV256     3'h4
`define ATS_CS_DIV1024    3'h5

`endif

// [ats_update_slot.v]
// Purpose: Temporary holding register with update-busy flag
// Assumes: oscTick is a one-cycle pulse per rising timer clock edge
// Notes:   Busy clear passes a two-stage pipeline after the load
`timescale 1ns/10ps
`include "ats_defs.vh"

module ats_update_slot #(
	parameter WIDTH = 8
) (
	input  wire             clk,       // System clock
	input  wire             rstN,      // Synchronised reset, active low
	input  wire             wrStrobe,  // Software write, one cycle
	input  wire [WIDTH-1:0] wrData,    // Written value
	input  wire             asyncMode, // Timer on oscillator clock
	input  wire             oscTick,   // Timer clock rising edge pulse
	output reg  [WIDTH-1:0] holdValue, // Temporary register contents
	output reg              loadPulse, // Load destination, one cycle
	output reg              busy       // Update busy flag
);

	reg       pending_reg;
	reg [1:0] edgeCnt_reg;
	reg [1:0] doneSync_reg;

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			holdValue    <= {WIDTH{1'b0}};
			loadPulse    <= 1'b0;
			busy         <= 1'b0;
			pending_reg  <= 1'b0;
			edgeCnt_reg  <= 2'h0;
			doneSync_reg <= 2'h0;
		end else begin
			loadPulse    <= 1'b0;
			doneSync_reg <= {doneSync_reg[0], 1'b0};
			if (doneSync_reg[1])
				busy <= 1'b0;
			if (wrStrobe) begin
				holdValue <= wrData;
				if (asyncMode) begin
					pending_reg <= 1'b1;
					edgeCnt_reg <= 2'h0;
					busy        <= 1'b1;
				end else begin
					pending_reg <= 1'b0;
					loadPulse   <= 1'b1;
				end
			end else if (pending_reg && oscTick) begin
				if (edgeCnt_reg + 2'h1 == `ATS_XFER_EDGES) begin
					pending_reg  <= 1'b0;
					loadPulse    <= 1'b1;
					doneSync_reg <= {doneSync_reg[0], 1'b1};
				end else begin
					edgeCnt_reg <= edgeCnt_reg + 2'h1;
				end
			end
		end
	end

endmodule // ats_update_slot

// [ats_timer_properties.sv]
// Purpose: Port-level properties of the async timer update block
// Assumes: Zero-wait APB slave with registered read data
// Notes:   Bound to the design top below
`timescale 1ns/10ps

module ats_timer_properties (
	input wire        sys_clk,   // System clock
	input wire        rst_n,     // Reset, active low
	input wire        psel,      // APB select
	input wire        penable,   // APB enable
	input wire        pwrite,    // APB direction
	input wire [11:0] paddr,     // APB address
	input wire [31:0] prdata,    // APB read data
	input wire        pready,    // APB ready
	input wire        pslverr,   // APB error
	input wire        powerSave, // Power save
	input wire        powerDown, // Power-down
	input wire        oscRun,    // Oscillator enable
	input wire        wakeReq,   // Wake request
	input wire        ovfFlag    // Overflow flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire aligned = paddr[1:0] == 2'h0;
	wire mapped  = aligned && paddr >= 12'h030 && paddr <= 12'h040;
	wire rdSetup = psel && !penable && !pwrite;

	chk_ready_high: assert property (pready)
		else $error("ready dropped");
	chk_err_hole: assert property (psel && penable && aligned && !mapped
		|-> pslverr) else $error("unmapped access not refused");
	chk_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
		else $error("mapped access refused");
	chk_status_rsvd: assert property (
		rdSetup && paddr == 12'h030 |=> prdata[31:4] == 28'h000_0000)
		else $error("reserved status bits set");
	chk_read_hold: assert property (!rdSetup |=> $stable(prdata))
		else $error("read data moved outside a read");
	chk_hole_zero: assert property (rdSetup && aligned && !mapped
		|=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
	chk_down_off: assert property (powerDown |-> !oscRun)
		else $error("oscillator runs in power-down");
	chk_wake_save: assert property (wakeReq |-> $past(powerSave))
		else $error("wake request outside power save");

	cover property (psel && penable && pslverr);
	cover property ($rose(wakeReq));
	cover property ($rose(ovfFlag));
endmodule // ats_timer_properties

bind ats_timer_top ats_timer_properties u_ats_timer_properties (
	.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .powerSave(powerSave), .powerDown(powerDown),
	.oscRun(oscRun), .wakeReq(wakeReq), .ovfFlag(ovfFlag));

// [async_timer_update_sync_tb.sv]
// Purpose: Self-checking bench for the async timer update block
// Assumes: Zero-wait APB, oscillator pin period of 16 system clocks
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/10ps

module async_timer_update_sync_tb;
	logic        sys_clk, rst_n, psel, penable, pwrite, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, c1;
	logic        pready, pslverr, oscClockPin, powerSave, powerDown;
	logic        oscRun, wakeReq, cmpOut, ovfFlag, cmpFlag;
	logic [2:0]  oscCnt;
	int          err_count, total_checks, n, cyc;
	time         t0;

	ats_timer_top #(.WIDTH(8)) u_ats_timer_top (
		.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .oscClockPin(oscClockPin),
		.powerSave(powerSave), .powerDown(powerDown), .oscRun(oscRun),
		.wakeReq(wakeReq), .cmpOut(cmpOut), .ovfFlag(ovfFlag),
		.cmpFlag(cmpFlag));

	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Oscillator pin toggles every 8 clocks, well under a quarter rate
	always @(posedge sys_clk) begin
		oscCnt <= oscCnt + 3'h1;
		if (oscCnt == 3'h7)
			oscClockPin <= ~oscClockPin;
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input [31:0] g, input [31:0] x);
		total_checks++;
		if (g !== x) begin
			err_count++;
			$display("FAIL %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic apb(input [11:0] a, input w, input [31:0] d);
		int k;
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'h1 && k < 16);
		if (k >= 16) begin
			err_count++;
			$display("FAIL %0t bus wait ran out", $time);
			wrap_up();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input [11:0] a);
		apb(a, 1'h0, 32'h0000_0000);
	endtask

	task automatic wr(input [11:0] a, input [31:0] d);
		apb(a, 1'h1, d);
	endtask

	// Polls status until all busy flags drop, cycles counted from t0
	task automatic wait_idle;
		n = 0;
		do begin
			rd(12'h030);
			n++;
		end while (q[2:0] !== 3'h0 && n < 60);
		chk(n < 60, 1'h1);
		cyc = ($time - t0) / 40;
	endtask

	task automatic s_reset;
		rd(12'h030);
		chk(q, 8'h00);
		rd(12'h038);
		chk(q, 8'h00);
		rd(12'h03C);
		chk(q, 8'h00);
	endtask

	task automatic s_sync;
		wr(12'h03C, 8'h01);
		rd(12'h030);
		chk(q, 8'h00);
		rd(12'h034);
		c1 = q;
		rd(12'h034);
		chk(q, c1 + 8'h03);
		chk(oscRun, 1'h0);
	endtask

	task automatic s_bus;
		rd(12'h044);
		chk(e, 1'h1);
		chk(q, 8'h00);
		wr(12'h030, 32'hFFFF_FFF8);
		rd(12'h030);
		chk(q, 8'h08);
	endtask

	task automatic s_async;
		t0 = $time;
		wr(12'h034, 8'h34);
		wr(12'h03C, 8'h01);
		wr(12'h038, 8'h12);
		rd(12'h030);
		chk(q, 8'h0F);
		rd(12'h038);
		chk(q, 8'h12);
		wait_idle();
		chk(cyc >= 16 && cyc <= 60, 1'h1);
		rd(12'h038);
		chk(q, 8'h12);
		rd(12'h03C);
		chk(q, 8'h01);
	endtask

	task automatic s_live;
		rd(12'h034);
		c1 = q;
		repeat (61) @(posedge sys_clk);
		rd(12'h034);
		chk(q, c1 + 8'h04);
	endtask

	task automatic s_power;
		chk(oscRun, 1'h1);
		powerDown <= 1'h1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk(oscRun, 1'h0);
		powerDown <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic s_wake;
		wr(12'h040, 8'h01);
		t0 = $time;
		wr(12'h034, 8'hFD);
		wait_idle();
		powerSave <= 1'h1;
		n = 0;
		while (wakeReq !== 1'h1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		chk(wakeReq, 1'h1);
		chk(ovfFlag, 1'h0);
		n = 0;
		while (ovfFlag !== 1'h1 && n < 24) begin
			@(posedge sys_clk);
			n++;
		end
		chk(ovfFlag, 1'h1);
		chk(n >= 3, 1'h1);
		powerSave <= 1'h0;
		wr(12'h040, 32'h0000_0101);
		chk(wakeReq, 1'h0);
		chk(ovfFlag, 1'h0);
	endtask

	// Stopped timer is armed, then run: compare toggles pin, then a
	// compare rewrite just before the next hit must hide that match
	task automatic s_match;
		wr(12'h040, 32'h0000_0300);
		wr(12'h03C, 8'h18);
		wr(12'h038, 8'h03);
		wr(12'h034, 8'h00);
		wait_idle();
		chk(cmpFlag, 1'h0);
		c1 = cmpOut;
		wr(12'h03C, 8'h19);
		wait_idle();
		n = 0;
		while (cmpOut === c1[0] && n < 120) begin
			@(posedge sys_clk);
			n++;
		end
		chk(cmpOut, !c1[0]);
		chk(cmpFlag, 1'h0);
		n = 0;
		while (cmpFlag !== 1'h1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		chk(cmpFlag, 1'h1);
		wr(12'h040, 32'h0000_0200);
		n = 0;
		do begin
			rd(12'h034);
			n++;
		end while (q !== 32'h0000_0002 && n < 40);
		chk(q, 8'h02);
		c1 = cmpOut;
		wr(12'h038, 8'h03);
		wait_idle();
		chk(cmpOut, c1[0]);
		chk(cmpFlag, 1'h0);
	endtask

	initial begin
		err_count    = 0;
		total_checks = 0;
		rst_n        = 1'h0;
		psel         = 1'h0;
		penable      = 1'h0;
		pwrite       = 1'h0;
		paddr        = 12'h000;
		pwdata       = 32'h0000_0000;
		powerSave    = 1'h0;
		powerDown    = 1'h0;
		oscClockPin  = 1'h0;
		oscCnt       = 3'h0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		s_reset();
		s_sync();
		s_bus();
		s_async();
		s_live();
		s_power();
		s_wake();
		s_match();
		wrap_up();
	end
endmodule // async_timer_update_sync_tb
